// File: hw/rtcs_calendar.v
// binary year and two-bit century counter with leap-year decode
`timescale 1ns/10ps
`include "rtcs_map.vh"
module rtcs_calendar (
  input  wire       clock,        // system clock
  input  wire       sys_rst,      // synchronous reset
  input  wire       year_tick,    // one-cycle year advance
  input  wire       load,         // software load of year and century
  input  wire [6:0] load_year,    // year value to load
  input  wire [1:0] load_century, // century value to load
  output reg  [6:0] year,         // year 0..99
  output reg        century_bit_lo, // century bit 0
  output reg        century_bit_hi, // century bit 1
  output wire       leap_year     // current year is a leap year
);
  function is_leap;
    input [6:0] y;
    input [1:0] c;
    begin
      if (y[1:0] != 2'b00)
        is_leap = 1'b0;
      else if (y == 7'h00)
        is_leap = (c == 2'b00);
      else
        is_leap = 1'b1;
    end
  endfunction
  wire [1:0] next_century = {century_bit_hi, century_bit_lo} + 2'b01;
  always @(posedge clock) begin
    if (sys_rst) begin
      year           <= 7'h00;
      century_bit_lo <= 1'b0;
      century_bit_hi <= 1'b0;
    end else if (load) begin
      year           <= load_year;
      century_bit_lo <= load_century[0];
      century_bit_hi <= load_century[1];
    end else if (year_tick) begin
      if (year == `RTCS_YEAR_LAST) begin
        year           <= 7'h00;
        century_bit_lo <= next_century[0];
        century_bit_hi <= next_century[1];
      end else begin
        year <= year + 7'h01;
      end
    end
  end
  assign leap_year = is_leap(year, {century_bit_hi, century_bit_lo});
endmodule

// File: hw/rtcs_edge_sync.v
// two-flop synchroniser with edge detect for the sampled oscillator clock
`timescale 1ns/10ps
module rtcs_edge_sync (
  input  wire clock,    // system clock
  input  wire sys_rst,  // synchronous reset
  input  wire async_in, // pin from another domain
  output reg  level,    // synchronised level
  output wire rise      // one-cycle rising edge
);
  reg meta;
  reg last;
  always @(posedge clock) begin
    if (sys_rst) begin
      meta  <= 1'b0;
      level <= 1'b0;
      last  <= 1'b0;
    end else begin
      meta  <= async_in;
      level <= meta;
      last  <= level;
    end
  end
  assign rise = level & ~last;
endmodule

// File: hw/rtcs_map.vh
// register map, field positions, defaults and timing constants for the rtc status block
// Contract
// - 32k output on at power-up, off by enable/halt
// - 32k output starts within about one second
// - two-bit century counts binary at rollover
// - leap year: div4, not div100 unless div400
// - no irq enabled: pin follows output bit
// - oscillator stop sets failure flag
// - failure flag is one at power-up
// - halt bit set sets failure flag
// - fail enable and flag drive irq low
// - fail irq released only by clearing writes
// - failure flag stays until written zero
// - stop during power-down still sets flag
// - documented power-on defaults loaded
// - other control bits undefined until written
// - alarm flag with enable drives irq pin
// - watchdog timeout sets flag, read clears it
`ifndef RTCS_MAP_VH
`define RTCS_MAP_VH
`define RTCS_REG_CTRL     4'h0
`define RTCS_REG_FLAGS    4'h4
`define RTCS_REG_WDOG     4'h8
`define RTCS_REG_TIME     4'hC
`define RTCS_CTRL_HALT    0
`define RTCS_CTRL_OSC_FAIL_IRQ_ENABLE    1
`define RTCS_CTRL_OUT     2
`define RTCS_CTRL_FT      3
`define RTCS_CTRL_AFE     4
`define RTCS_CTRL_SQUARE_WAVE_ENABLE    5
`define RTCS_CTRL_CLK32K_OUTPUT_ENABLE    6
`define RTCS_CTRL_RS_LO   8
`define RTCS_CTRL_RS_HI   11
`define RTCS_FLAG_OF      0
`define RTCS_FLAG_AF      1
`define RTCS_FLAG_WDF     2
`define RTCS_FLAG_RUN     3
`define RTCS_CTRL_RESET   32'h0000_0164
`define RTCS_WD_RESET     8'h00
`define RTCS_RS_DEFAULT   4'h1
`define RTCS_YEAR_LAST    7'h63
`define RTCS_STOP_EDGES   16'h0800
`define RTCS_START_EDGES  16'h8000
`define RTCS_AXI_OKAY     2'b00
`define RTCS_AXI_SLVERR   2'b10
`endif

// File: hw/rtcs_top.v
// oscillator-fail flag, interrupt/output pin and 32k output control with axi4-lite registers
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`include "rtcs_map.vh"
module rtcs_top (
  input  wire        clock,          // 125 MHz system clock
  input  wire        sys_rst,        // synchronous power-on reset
  input  wire        osc_clk,        // 32.768 kHz oscillator, sampled
  input  wire        alarm_match,    // one-cycle alarm match event
  input  wire        year_tick,      // one-cycle year advance
  input  wire [31:0] s_axi_awaddr,   // write address
  input  wire        s_axi_awvalid,  // write address valid
  output wire        s_axi_awready,  // write address ready
  input  wire [31:0] s_axi_wdata,    // write data
  input  wire [3:0]  s_axi_wstrb,    // write strobes
  input  wire        s_axi_wvalid,   // write data valid
  output wire        s_axi_wready,   // write data ready
  output reg  [1:0]  s_axi_bresp,    // write response
  output reg         s_axi_bvalid,   // write response valid
  input  wire        s_axi_bready,   // write response ready
  input  wire [31:0] s_axi_araddr,   // read address
  input  wire        s_axi_arvalid,  // read address valid
  output wire        s_axi_arready,  // read address ready
  output reg  [31:0] s_axi_rdata,    // read data
  output reg  [1:0]  s_axi_rresp,    // read response
  output reg         s_axi_rvalid,   // read data valid
  input  wire        s_axi_rready,   // read data ready
  output wire        irq_out_o,      // irq/out pin output level (always 0)
  output wire        irq_out_oe,     // irq/out open-drain enable, high pulls low
  output reg         fixed_32k_pin,  // fixed 32 kHz output
  output wire        leap_year       // current year is a leap year
);
  reg  [31:0] ctrl;
  reg  [7:0]  wdog;
  reg         oscillator_failure_flag;
  reg         alarm_match_flag;
  reg         watchdog_expired_flag;
  reg         osc_running;
  reg  [15:0] stop_cnt;
  reg  [15:0] run_cnt;
  reg  [15:0] wd_cnt;
  reg         aw_got;
  reg         w_got;
  reg  [3:0]  aw_addr;
  reg         aw_bad;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire        osc_level;
  wire        osc_rise;
  wire [6:0]  year;
  wire        century_bit_lo;
  wire        century_bit_hi;

  wire halt_oscillator      = ctrl[`RTCS_CTRL_HALT];
  wire osc_fail_irq_enable  = ctrl[`RTCS_CTRL_OSC_FAIL_IRQ_ENABLE];
  wire out_level            = ctrl[`RTCS_CTRL_OUT];
  wire freq_test_select     = ctrl[`RTCS_CTRL_FT];
  wire alarm_irq_enable     = ctrl[`RTCS_CTRL_AFE];
  wire square_wave_enable   = ctrl[`RTCS_CTRL_SQUARE_WAVE_ENABLE];
  wire clk32k_output_enable = ctrl[`RTCS_CTRL_CLK32K_OUTPUT_ENABLE];
  wire [3:0] square_rate_select = ctrl[`RTCS_CTRL_RS_HI:`RTCS_CTRL_RS_LO];

  rtcs_edge_sync u_osc_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in (osc_clk),
    .level    (osc_level),
    .rise     (osc_rise)
  );

  // oscillator presence: no edge for a long gap means stopped; needs a
  // stretch of edges to count as started (start-up delay of the crystal)
  wire osc_stopped = (stop_cnt == `RTCS_STOP_EDGES);
  always @(posedge clock) begin
    if (sys_rst) begin
      stop_cnt    <= 16'h0000;
      run_cnt     <= 16'h0000;
      osc_running <= 1'b0;
    end else begin
      if (osc_rise)
        stop_cnt <= 16'h0000;
      else if (!osc_stopped)
        stop_cnt <= stop_cnt + 16'h0001;
      if (osc_stopped || halt_oscillator) begin
        run_cnt     <= 16'h0000;
        osc_running <= 1'b0;
      end else if (osc_rise && !osc_running) begin
        run_cnt <= run_cnt + 16'h0001;
        if (run_cnt == `RTCS_START_EDGES)
          osc_running <= 1'b1;
      end
    end
  end

  // 32k output mirrors the sampled crystal; quiet when halted or disabled
  always @(posedge clock) begin
    if (sys_rst)
      fixed_32k_pin <= 1'b0;
    else
      fixed_32k_pin <= osc_level & osc_running & clk32k_output_enable
                       & ~halt_oscillator;
  end

  // unmapped writes answer slverr and touch nothing
  wire wr_fire = aw_got & w_got;
  wire wr_ok   = wr_fire & ~aw_bad;

  rtcs_calendar u_cal (
    .clock          (clock),
    .sys_rst        (sys_rst),
    .year_tick      (year_tick),
    .load           (wr_ok && aw_addr == `RTCS_REG_TIME && w_strb[0]),
    .load_year      (w_data[6:0]),
    .load_century   (w_data[9:8]),
    .year           (year),
    .century_bit_lo (century_bit_lo),
    .century_bit_hi (century_bit_hi),
    .leap_year      (leap_year)
  );

  // axi4-lite write: address and data accepted in either order
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  wire aw_now  = s_axi_awvalid & s_axi_awready;
  wire w_now   = s_axi_wvalid & s_axi_wready;
  always @(posedge clock) begin
    if (sys_rst) begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_addr      <= 4'h0;
      aw_bad       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RTCS_AXI_OKAY;
    end else begin
      if (aw_now) begin
        aw_got  <= 1'b1;
        aw_addr <= {s_axi_awaddr[3:2], 2'b00};
        aw_bad  <= (s_axi_awaddr[31:4] != 28'h0000000);
      end
      if (w_now) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_bad ? `RTCS_AXI_SLVERR : `RTCS_AXI_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire wr_ctrl  = wr_ok && aw_addr == `RTCS_REG_CTRL;
  wire wr_flags = wr_ok && aw_addr == `RTCS_REG_FLAGS;
  wire wr_wdog  = wr_ok && aw_addr == `RTCS_REG_WDOG;
  wire rd_fire  = s_axi_arvalid & s_axi_arready;
  wire rd_flags = rd_fire && s_axi_araddr[5:0] == {2'b00, `RTCS_REG_FLAGS};
  wire halt_set = wr_ctrl && w_strb[0] && w_data[`RTCS_CTRL_HALT];

  // control register; fields without a documented default also reset here
  // to keep simulation clean, software must still not rely on them
  always @(posedge clock) begin
    if (sys_rst)
      ctrl <= `RTCS_CTRL_RESET;
    else if (wr_ctrl) begin
      if (w_strb[0])
        ctrl[7:0] <= w_data[7:0];
      if (w_strb[1])
        ctrl[15:8] <= w_data[15:8];
    end
  end

  // watchdog: units of 1/128 s (256 crystal edges) counted on crystal edges, simplified
  wire wd_armed = (wdog != `RTCS_WD_RESET);
  always @(posedge clock) begin
    if (sys_rst) begin
      wdog   <= `RTCS_WD_RESET;
      wd_cnt <= 16'h0000;
    end else if ((wr_wdog && w_strb[0]) || wr_ctrl) begin
      if (wr_wdog)
        wdog <= w_data[7:0];
      wd_cnt <= 16'h0000;
    end else if (wd_armed && osc_rise && osc_running) begin
      if (wd_cnt[15:8] >= wdog) begin
        wdog   <= `RTCS_WD_RESET;
        wd_cnt <= 16'h0000;
      end else
        wd_cnt <= wd_cnt + 16'h0001;
    end
  end
  wire wd_timeout = wd_armed && osc_rise && osc_running && wd_cnt[15:8] >= wdog
                    && !wr_wdog && !wr_ctrl;

  // flags: hardware set wins over software clear
  always @(posedge clock) begin
    if (sys_rst) begin
      oscillator_failure_flag <= 1'b1;
      alarm_match_flag        <= 1'b0;
      watchdog_expired_flag   <= 1'b0;
    end else begin
      if (osc_stopped || halt_set || halt_oscillator)
        oscillator_failure_flag <= 1'b1;
      else if (wr_flags && w_strb[0] && !w_data[`RTCS_FLAG_OF])
        oscillator_failure_flag <= 1'b0;
      if (alarm_match)
        alarm_match_flag <= 1'b1;
      else if (rd_flags)
        alarm_match_flag <= 1'b0;
      if (wd_timeout)
        watchdog_expired_flag <= 1'b1;
      else if (rd_flags)
        watchdog_expired_flag <= 1'b0;
    end
  end

  // irq/out pin: open drain, enable high pulls the wire low
  wire of_irq  = osc_fail_irq_enable & oscillator_failure_flag;
  wire af_irq  = alarm_irq_enable & alarm_match_flag;
  wire any_en  = osc_fail_irq_enable | alarm_irq_enable | wd_armed;
  wire pull_lo = any_en ? (of_irq | af_irq | watchdog_expired_flag)
                        : ~(out_level | (freq_test_select & 1'b0));
  assign irq_out_oe = pull_lo;
  assign irq_out_o  = 1'b0;

  // axi4-lite read, one cycle to answer
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge clock) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RTCS_AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RTCS_AXI_OKAY;
      case (s_axi_araddr[5:0])
        {2'b00, `RTCS_REG_CTRL}:
          s_axi_rdata <= {20'h00000, square_rate_select, 1'b0, clk32k_output_enable,
                          square_wave_enable, ctrl[4:0]};
        {2'b00, `RTCS_REG_FLAGS}:
          s_axi_rdata <= {28'h0000000, osc_running, watchdog_expired_flag,
                          alarm_match_flag, oscillator_failure_flag};
        {2'b00, `RTCS_REG_WDOG}:
          s_axi_rdata <= {24'h000000, wdog};
        {2'b00, `RTCS_REG_TIME}:
          s_axi_rdata <= {21'h000000, leap_year, century_bit_hi, century_bit_lo,
                          1'b0, year};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RTCS_AXI_SLVERR;
        end
      endcase
      if (s_axi_araddr[31:6] != 26'h0) begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `RTCS_AXI_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: test/rtc_osc_fail_and_output_control_test.sv
// self-checking bench for the rtc status block
`timescale 1ns/10ps
module rtc_osc_fail_and_output_control_test;
  logic clock = 1'b0, sys_rst = 1'b1, run = 1'b1, alarm_match = 1'b0, year_tick = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, m_of = 1'b1, m_af = 1'b0;
  logic [31:0] m_ctrl = 32'h164;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire irq_out_oe, fixed_32k_pin, leap_year, osc_clk;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int err_total = 0, num_checks = 0, seed = 73, i, y, c;
  always #4 clock = ~clock;
  rtcs_osc_model u_osc (.run, .osc_clk);
  rtcs_top u_dut (.clock, .sys_rst, .osc_clk, .alarm_match, .year_tick, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_out_o(),
    .irq_out_oe, .fixed_32k_pin, .leap_year);
  function logic m_oe();
    return (m_ctrl[1] & m_of) | (m_ctrl[4] & m_af) | (!m_ctrl[1] & !m_ctrl[4] & !m_ctrl[2]);
  endfunction
  function logic lp(int y, int c);
    return (y % 4 == 0) && (y != 0 || c == 0);
  endfunction
  task test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [63:0] g, e, input string m);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task hang();
    chk(0, 1, "bus wait ran out");
    test_done();
  endtask
  task wr(input logic [31:0] a, v);
    int n;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (n == 50) hang();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [31:0] a);
    int n;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (n == 50) hang();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task wc(input logic [31:0] v);
    m_ctrl = v;
    wr(32'h0, v);
  endtask
  task pc(input string m);
    repeat (2) @(posedge clock);
    #1;
    chk(irq_out_oe, m_oe(), m);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    rd(32'h0);
    chk(d & 32'hF77, m_ctrl & 32'hF77, "ctrl defaults");
    rd(32'h4);
    chk(d[2:0], {2'b00, m_of}, "flag defaults");
    pc("pin at idle");
    for (i = 0; i < 2; i++) begin
      wc(m_ctrl ^ 32'h4);
      pc("out bit");
    end
    $display("defaults and out test done");
    wc(m_ctrl | 32'h2);
    pc("fail irq");
    for (i = 0; i < 2; i++) begin
      rd(32'h4);
      chk(d[0], 1, "flag held over read");
    end
    pc("fail irq after read");
    wr(32'h4, 32'h1);
    rd(32'h4);
    chk(d[0], 1, "flag kept by write of one");
    wr(32'h4, 32'h0);
    m_of = 1'b0;
    pc("fail irq released");
    $display("fail irq test done");
    wc(m_ctrl | 32'h1);
    m_of = 1'b1;
    rd(32'h4);
    chk(d[0], m_of, "halt sets flag");
    chk(fixed_32k_pin, 0, "32k quiet in halt");
    pc("halt irq");
    wc(m_ctrl & ~32'h1);
    wr(32'h4, 32'h0);
    m_of = 1'b0;
    rd(32'h4);
    chk(d[0], m_of, "flag cleared after restart");
    run <= 1'b0;
    repeat (2100) @(posedge clock);
    m_of = 1'b1;
    rd(32'h4);
    chk(d[0], m_of, "stop sets flag");
    pc("stop irq");
    run <= 1'b1;
    repeat (100) @(posedge clock);
    wr(32'h4, 32'h0);
    m_of = 1'b0;
    wc(m_ctrl & ~32'h2);
    $display("halt and stop test done");
    wc(m_ctrl | 32'h10);
    alarm_match <= 1'b1;
    @(posedge clock);
    alarm_match <= 1'b0;
    m_af = 1'b1;
    pc("alarm irq");
    rd(32'h4);
    chk(d[1], m_af, "alarm flag");
    m_af = 1'b0;
    pc("alarm irq cleared by read");
    wc(m_ctrl & ~32'h10);
    $display("alarm test done");
    for (i = 0; i < 12; i++) begin
      y = (i < 4) ? 99 : $unsigned($random(seed)) % 100;
      c = (i < 4) ? i : $unsigned($random(seed)) % 4;
      wr(32'hC, {22'h0, c[1:0], 1'b0, y[6:0]});
      if (i < 4) begin
        year_tick <= 1'b1;
        @(posedge clock);
        year_tick <= 1'b0;
        y = 0;
        c = (c + 1) % 4;
      end
      rd(32'hC);
      chk({d[10:8], d[6:0]}, {lp(y, c), c[1:0], y[6:0]}, "year and century");
      chk(leap_year, lp(y, c), "leap pin");
    end
    $display("calendar test done");
    rd(32'h10);
    chk({r, d}, {2'b10, 32'h0}, "unmapped read");
    wr(32'h10, 32'hFFFF);
    chk(r, 2'b10, "unmapped write");
    $display("unmapped test done");
    test_done();
  end
endmodule

// File: test/rtcs_checker_properties.sv
// assertions on the rtc status block ports
`timescale 1ns/10ps
`include "rtcs_map.vh"
module rtcs_checker (
  input wire        clock,         // system clock
  input wire        sys_rst,       // sync reset
  input wire        alarm_match,   // alarm event
  input wire [31:0] s_axi_awaddr,  // write address
  input wire        s_axi_awvalid, // aw valid
  input wire        s_axi_awready, // aw ready
  input wire [31:0] s_axi_wdata,   // write data
  input wire        s_axi_wvalid,  // w valid
  input wire        s_axi_wready,  // w ready
  input wire        s_axi_bvalid,  // b valid
  input wire [31:0] s_axi_araddr,  // read address
  input wire        s_axi_arvalid, // ar valid
  input wire        s_axi_arready, // ar ready
  input wire [31:0] s_axi_rdata,   // read data
  input wire [1:0]  s_axi_rresp,   // read response
  input wire        s_axi_rvalid,  // r valid
  input wire        irq_out_o,     // pin level
  input wire        irq_out_oe,    // pin pull-low
  input wire        fixed_32k_pin  // 32k output
);
  logic [31:0] sh;
  logic [31:0] ra;
  logic [7:0]  wd;
  logic        rst_d;
  // shadow of ctrl; captured only when aw and w are taken in the same cycle, judged at bvalid
  always @(posedge clock) begin
    rst_d <= sys_rst;
    if (sys_rst) begin
      sh <= `RTCS_CTRL_RESET;
      wd <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) begin
      if (s_axi_awaddr == 32'h0) sh <= s_axi_wdata;
      if (s_axi_awaddr == 32'h8) wd <= s_axi_wdata[7:0];
    end
    if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_of_seen;
    s_axi_rvalid && ra == 32'h4 && s_axi_rdata[0];
  endsequence
  property p_rst;
    rst_d && !sys_rst |-> !irq_out_oe && !fixed_32k_pin;
  endproperty
  property p_out;
    s_axi_bvalid && !sh[1] && !sh[4] && wd == 8'h00 |-> irq_out_oe == !sh[2];
  endproperty
  property p_osc_fail_irq_enable;
    s_of_seen ##0 sh[1] |-> irq_out_oe ##1 irq_out_oe;
  endproperty
  property p_halt_of;
    s_axi_rvalid && ra == 32'h4 && sh[0] |-> s_axi_rdata[0];
  endproperty
  property p_32k;
    s_axi_bvalid && (sh[0] || !sh[6]) |-> !fixed_32k_pin;
  endproperty
  property p_leap;
    s_axi_rvalid && ra == 32'hC |-> s_axi_rdata[10] == (s_axi_rdata[1:0] == 2'b00 &&
      (s_axi_rdata[6:0] != 7'h00 || s_axi_rdata[9:8] == 2'b00));
  endproperty
  property p_alarm;
    alarm_match && sh[4] |-> ##[1:2] irq_out_oe;
  endproperty
  property p_bad;
    s_axi_rvalid && ra == 32'h10 |-> s_axi_rresp == `RTCS_AXI_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  property p_bresp;
    s_wr_take |-> ##[1:3] s_axi_bvalid;
  endproperty
  property p_drain;
    irq_out_oe |-> !irq_out_o;
  endproperty
  a_rst: assert property (p_rst) else $error("pin state after reset");
  a_out: assert property (p_out) else $error("pin not following out bit");
  a_osc_fail_irq_enable: assert property (p_osc_fail_irq_enable) else $error("fail irq missing");
  a_halt_of: assert property (p_halt_of) else $error("halt left flag clear");
  a_32k: assert property (p_32k) else $error("32k pin active");
  a_leap: assert property (p_leap) else $error("leap bit wrong");
  a_alarm: assert property (p_alarm) else $error("alarm irq missing");
  a_bad: assert property (p_bad) else $error("unmapped read answer");
  a_bresp: assert property (p_bresp) else $error("write response late");
  a_drain: assert property (p_drain) else $error("pin driven high");
endmodule
bind rtcs_top rtcs_checker u_chk (.clock, .sys_rst, .alarm_match, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .irq_out_o, .irq_out_oe, .fixed_32k_pin);

// File: test/rtcs_osc_model.sv
// crystal oscillator model feeding the sampled 32 kHz pin
`timescale 1ns/10ps
module rtcs_osc_model (
  input  wire run,    // high lets the crystal swing
  output reg  osc_clk // oscillator output
);
  // offset keeps edges away from the system clock edges; a stopped crystal freezes
  initial begin
    osc_clk = 1'b0;
    #1.3;
    forever #62.5 if (run) osc_clk = ~osc_clk;
  end
endmodule
